/* File: design/readout_pkg.sv */
// Shared constants, register map and carrier types for the voltage input readout.
package readout_pkg;

  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int CLK_MHZ = 200;
  localparam int INTEG_50_US = 20000;
  localparam int INTEG_60_US = 16660;
  localparam int TEST_US = 10;
  localparam int INTEG_50_CYC = INTEG_50_US * CLK_MHZ;
  localparam int INTEG_60_CYC = INTEG_60_US * CLK_MHZ;
  localparam int TEST_CYC = TEST_US * CLK_MHZ;
  localparam int TMR_W = 23;

  // ==========================================================================
  // Register map (byte addresses)
  // ==========================================================================
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
  localparam logic [7:0] OFS_WORD0 = 8'h10;
  localparam logic [7:0] OFS_WORD3 = 8'h1c;

  // Control fields: [0] mains 60 Hz, [2:1] channel count, [3] break reporting.
  localparam int CTRL_MAINS_BIT = 0;
  localparam int CTRL_NCH_LSB = 1;
  localparam int CTRL_BRK_BIT = 3;
  localparam logic [3:0] CTRL_RST = 4'hc;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Channel count settings.
  localparam logic [1:0] NCH_ONE = 2'h0;
  localparam logic [1:0] NCH_TWO = 2'h1;

  // ==========================================================================
  // Measurement word layout
  // ==========================================================================
  localparam int W_OVF_BIT = 0;
  localparam int W_BRK_BIT = 1;
  localparam int W_VAL_LSB = 3;
  localparam logic signed [15:0] MAX_UNITS = 16'sh0fff;

  typedef struct packed {
    logic done;
    logic signed [15:0] count;
  } conv_res_t;

  typedef struct packed {
    logic [1:0] chan;
    logic [15:0] word;
  } meas_t;

  typedef enum logic [1:0] {
    ST_TEST = 2'b00,
    ST_INTEG = 2'b01,
    ST_WAIT = 2'b10
  } scan_state_t;

endpackage

/* File: design/period_timer.sv */
// Loadable down-counter that pulses done when a timed phase ends.
module period_timer #(
  parameter int W = 23
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  output logic done
);

  logic [W-1:0] cnt_q;
  logic run_q;

  // ==========================================================================
  // Counter
  // ==========================================================================
  // A load of N gives done exactly N cycles after the load cycle.
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end
    else if (load)
    begin
      cnt_q <= load_val;
      run_q <= 1'b1;
    end
    else if (run_q)
    begin
      cnt_q <= cnt_q - 1'b1;
      run_q <= (cnt_q != W'(1));
    end
  end

  assign done = run_q && (cnt_q == W'(1));

endmodule

/* File: design/word_format.sv */
// Converts a signed unit count into the left-justified measurement word.
module word_format
  import readout_pkg::*;
(
  input wire logic signed [15:0] count,
  input wire logic brk,
  output logic [15:0] word
);

  // ==========================================================================
  // Saturation and packing
  // ==========================================================================
  // Beyond 4095 units the value clamps and bit 0 flags the overflow.
  wire over_pos = count > MAX_UNITS;
  wire over_neg = count < -MAX_UNITS;
  wire signed [15:0] sat = over_pos ? MAX_UNITS : (over_neg ? -MAX_UNITS : count);
  wire ovf = over_pos | over_neg;

  // Value in bits 15..3, bit 2 zero, break flag bit 1, overflow bit 0.
  assign word = {sat[12:0], 1'b0, brk, ovf};

endmodule

/* File: design/voltage_readout.sv */
// Four-channel bipolar voltage input readout with scan, wire-break check and AXI4-Lite registers.
//
// Notes on behaviour
// - Integration lasts 20 ms at 50 Hz mains, 16.66 ms at 60 Hz.
// - Channel count of one, two or four selects channels 0, 0-1 or 0-3.
// - Fewer channels scanned means each active channel refreshes more often.
// - Wire breaks reported in word, indicator and interrupt only while break reporting is enabled; the status register always shows them.
// - A reported break lights the red indicator and sets word bit 1.
// - Test current pulses drive the input; break when voltage exceeds the limit.
// - Test current pulses continue even with break reporting disabled.
// - Word is 16-bit two's complement, unit LSB at bit 3, 2048 = 1000 mV.
// - Magnitudes 2049 to 4095 pass unchanged with no overflow bit.
// - Above +4095 the word is +4095 with bit 0 set.
// - Below -4095 the word is -4095 with bit 0 set.
module voltage_readout
  import readout_pkg::*;
#(
  parameter int INTEG_50 = INTEG_50_CYC,
  parameter int INTEG_60 = INTEG_60_CYC
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [readout_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [readout_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [1:0] mux_sel,
  output logic test_current,
  output logic integ_en,
  input wire logic over_limit,
  input wire readout_pkg::conv_res_t conv_res,
  output readout_pkg::meas_t meas,
  output logic meas_valid,
  output logic fault_led,
  output logic irq
);

  import readout_pkg::*;

  // ==========================================================================
  // Declarations
  // ==========================================================================
  scan_state_t state_q, state_d;
  logic [1:0] chan_q, chan_d;
  logic [3:0] ctrl_q;
  logic [7:0] irq_stat_q, irq_mask_q;
  logic [3:0] brk_q;
  logic [15:0] word_q [4];
  logic aw_got_q, w_got_q, bvalid_q, rvalid_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic wstrb0_q;
  logic [1:0] rresp_q, bresp_q;
  meas_t meas_q;
  logic meas_valid_q;
  logic fault_led_q;
  logic test_q, integ_q;
  logic first_q;

  // ==========================================================================
  // Control decode
  // ==========================================================================
  wire mains_60 = ctrl_q[CTRL_MAINS_BIT];
  wire [1:0] nch_sel = ctrl_q[CTRL_NCH_LSB +: 2];
  wire brk_report = ctrl_q[CTRL_BRK_BIT];

  // Last active channel; an unused setting code scans all four.
  wire [1:0] last_chan = (nch_sel == NCH_ONE) ? 2'd0 : ((nch_sel == NCH_TWO) ? 2'd1 : 2'd3);

  // Integration length follows the mains setting for best hum rejection.
  wire [TMR_W-1:0] integ_len = mains_60 ? TMR_W'(INTEG_60) : TMR_W'(INTEG_50);

  // ==========================================================================
  // Phase timer
  // ==========================================================================
  logic tmr_done;
  wire tmr_load = (state_q != state_d) && (state_d != ST_WAIT);
  wire [TMR_W-1:0] tmr_val = (state_d == ST_INTEG) ? integ_len : TMR_W'(TEST_CYC);

  period_timer #(
    .W(TMR_W)
  ) u_timer (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .load(tmr_load | first_q),
    .load_val(tmr_val),
    .done(tmr_done)
  );

  // First cycle after reset starts the test phase of channel 0.
  always_ff @(posedge sys_clk)
  begin
    first_q <= !rstn;
  end

  // ==========================================================================
  // Scan sequence: test pulse, integrate, wait for the count
  // ==========================================================================
  wire chan_wrap = (chan_q >= last_chan);
  wire [1:0] chan_next = chan_wrap ? 2'd0 : chan_q + 2'd1;

  always_comb
  begin
    state_d = state_q;
    chan_d = chan_q;
    case (state_q)
      ST_TEST:
      begin
        if (tmr_done)
        begin
          state_d = ST_INTEG;
        end
      end
      ST_INTEG:
      begin
        if (tmr_done)
        begin
          state_d = ST_WAIT;
        end
      end
      ST_WAIT:
      begin
        if (conv_res.done)
        begin
          state_d = ST_TEST;
          chan_d = chan_next;
        end
      end
      default:
      begin
        state_d = ST_TEST;
        chan_d = 2'd0;
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      state_q <= ST_TEST;
      chan_q <= 2'd0;
    end
    else
    begin
      state_q <= state_d;
      chan_q <= chan_d;
    end
  end

  // ==========================================================================
  // Front-end drive
  // ==========================================================================
  // The test current runs whatever the reporting setting, so readings always
  // carry the same small ripple and the check never goes stale.
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      test_q <= 1'b0;
      integ_q <= 1'b0;
    end
    else
    begin
      test_q <= (state_d == ST_TEST);
      integ_q <= (state_d == ST_INTEG);
    end
  end

  // The comparator is sampled at the end of the test pulse.
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      brk_q <= 4'h0;
    end
    else if (state_q == ST_TEST && tmr_done)
    begin
      brk_q[chan_q] <= over_limit;
    end
  end

  // ==========================================================================
  // Measurement words
  // ==========================================================================
  logic [15:0] fmt_word;
  word_format u_fmt (
    .count(conv_res.count),
    .brk(brk_q[chan_q] & brk_report),
    .word(fmt_word)
  );

  wire store = (state_q == ST_WAIT) && conv_res.done;

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < 4; i++)
      begin
        word_q[i] <= 16'h0000;
      end
      meas_q <= '0;
      meas_valid_q <= 1'b0;
    end
    else
    begin
      meas_valid_q <= store;
      if (store)
      begin
        word_q[chan_q] <= fmt_word;
        meas_q <= '{chan: chan_q, word: fmt_word};
      end
    end
  end

  // Indicator follows any stored break, and only while reporting is on.
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      fault_led_q <= 1'b0;
    end
    else
    begin
      fault_led_q <= brk_report && (|brk_q);
    end
  end

  // ==========================================================================
  // AXI4-Lite write channel
  // ==========================================================================
  wire wr_go = aw_got_q && w_got_q && !bvalid_q;
  wire wr_ctrl = wr_go && (awaddr_q == OFS_CTRL) && wstrb0_q;
  wire wr_stat = wr_go && (awaddr_q == OFS_IRQ_STAT) && wstrb0_q;
  wire wr_mask = wr_go && (awaddr_q == OFS_IRQ_MASK) && wstrb0_q;
  wire wr_known = (awaddr_q == OFS_CTRL) || (awaddr_q == OFS_IRQ_STAT) || (awaddr_q == OFS_IRQ_MASK);

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      awaddr_q <= '0;
      wdata_q <= 32'h0000_0000;
      wstrb0_q <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb0_q <= s_axi_wstrb[0];
      end
      if (wr_go)
      begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_q && s_axi_bready)
      begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Registers written by software; status bits set by hardware win over a clear.
  wire [7:0] irq_events = {brk_q[chan_q] & store & brk_report, 3'b000, 4'h0} | {4'h0, {3'b000, store} << chan_q};

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      ctrl_q <= CTRL_RST;
      irq_mask_q <= MASK_RST;
      irq_stat_q <= 8'h00;
    end
    else
    begin
      if (wr_ctrl)
      begin
        ctrl_q <= wdata_q[3:0];
      end
      if (wr_mask)
      begin
        irq_mask_q <= wdata_q[7:0];
      end
      irq_stat_q <= (irq_stat_q & ~(wr_stat ? wdata_q[7:0] : 8'h00)) | irq_events;
    end
  end

  // ==========================================================================
  // AXI4-Lite read channel
  // ==========================================================================
  wire [ADDR_W-1:0] ra = s_axi_araddr;
  wire rd_word = (ra >= OFS_WORD0) && (ra <= OFS_WORD3) && (ra[1:0] == 2'b00);
  wire [31:0] rd_val =
    (ra == OFS_CTRL) ? {28'h0, ctrl_q} :
    (ra == OFS_STATUS) ? {24'h0, brk_q, 1'b0, chan_q, fault_led_q} :
    (ra == OFS_IRQ_STAT) ? {24'h0, irq_stat_q} :
    (ra == OFS_IRQ_MASK) ? {24'h0, irq_mask_q} :
    rd_word ? {16'h0, word_q[ra[3:2]]} : 32'h0000_0000;
  wire rd_known = rd_word || (ra == OFS_CTRL) || (ra == OFS_STATUS) || (ra == OFS_IRQ_STAT) || (ra == OFS_IRQ_MASK);

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_val;
      rresp_q <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid_q && s_axi_rready)
    begin
      rvalid_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign s_axi_awready = !aw_got_q && !bvalid_q;
  assign s_axi_wready = !w_got_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign mux_sel = chan_q;
  assign test_current = test_q;
  assign integ_en = integ_q;
  assign meas = meas_q;
  assign meas_valid = meas_valid_q;
  assign fault_led = fault_led_q;
  assign irq = |(irq_stat_q & irq_mask_q);

endmodule

/* File: dv/adc_model.sv */
// Behavioural converter and break-sense model at the far side of the readout.
module adc_model
  import readout_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [1:0] mux_sel,
  input wire logic test_current,
  input wire logic integ_en,
  input wire logic signed [15:0] cnt [4],
  input wire logic [3:0] open_wire,
  input wire logic [3:0] lag,
  output logic over_limit,
  output conv_res_t conv_res
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] dly_q;
  logic junk_q;

  // =========================================
  // Break sense
  // =========================================
  // Outside the test phase the line toggles, so a stale level never reads as valid.
  assign over_limit = test_current ? open_wire[mux_sel] : junk_q;

  // =========================================
  // Conversion result
  // =========================================
  // The result lags the end of integration by lag cycles; the count is junk between pulses.
  always_ff @(posedge sys_clk)
  begin
    junk_q <= rstn ? !junk_q : 1'b0;
    dly_q <= !rstn ? 4'h0 : (integ_en ? lag : (dly_q == 4'h0 ? 4'h0 : dly_q - 4'h1));
    conv_res.done <= rstn && !integ_en && dly_q == 4'h1;
    conv_res.count <= (dly_q == 4'h1) ? cnt[mux_sel] : {16{junk_q}};
  end
endmodule

/* File: dv/readout_monitor.sv */
// Port-level assertions for the voltage readout.
module readout_monitor
  import readout_pkg::*;
#(
  parameter int INTEG_50 = INTEG_50_CYC,
  parameter int INTEG_60 = INTEG_60_CYC
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [1:0] mux_sel,
  input wire logic test_current,
  input wire logic integ_en,
  input wire readout_pkg::conv_res_t conv_res,
  input wire readout_pkg::meas_t meas,
  input wire logic meas_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  int tc_q;
  int ie_q;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  // =========================================
  // Phase length counters
  // =========================================
  // Counting the high run is cheaper than a long repetition in a property.
  always_ff @(posedge sys_clk)
  begin
    tc_q <= test_current ? tc_q + 1 : 0;
    ie_q <= integ_en ? ie_q + 1 : 0;
  end

  // =========================================
  // Assertions
  // =========================================
  a_test_len: assert property ($fell(test_current) |-> tc_q == TEST_CYC)
    else $error("test current phase has the wrong length");
  a_integ_len: assert property ($fell(integ_en) |-> ie_q == INTEG_50 || ie_q == INTEG_60)
    else $error("integration length matches neither mains setting");
  a_integ_after: assert property ($fell(test_current) |-> ##[0:2] integ_en)
    else $error("integration did not follow the test phase");
  a_phase_excl: assert property (!(test_current && integ_en))
    else $error("test current applied during integration");
  a_mux_hold: assert property (test_current && $past(test_current) |-> $stable(mux_sel))
    else $error("channel select moved during the test phase");
  a_store_done: assert property (conv_res.done && !integ_en && !test_current |-> ##[1:2] meas_valid)
    else $error("finished conversion was not stored");
  a_ovf_code: assert property (meas.word[W_OVF_BIT] |-> meas.word[15:3] inside {13'h0fff, 13'h1001})
    else $error("overflow flag without a saturated value");
  a_pad_zero: assert property (meas_valid |-> meas.word[2] == 1'b0)
    else $error("unused word bit is set");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read address taken without an answer");
endmodule

bind voltage_readout readout_monitor #(.INTEG_50(INTEG_50), .INTEG_60(INTEG_60)) mon (.sys_clk, .rstn,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .mux_sel, .test_current, .integ_en, .conv_res, .meas,
  .meas_valid);

/* File: dv/test_bipolar_voltage_input_readout.sv */
// Self-checking bench for the bipolar voltage input readout.
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
  $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module test_bipolar_voltage_input_readout;
  import readout_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, rstn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, test_current, integ_en, over_limit;
  logic meas_valid, fault_led, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, open_wire, lag;
  logic [1:0] s_axi_bresp, s_axi_rresp, mux_sel, mc, pc;
  logic [15:0] mw;
  logic signed [15:0] cnt [4];
  conv_res_t conv_res;
  meas_t meas;
  int bad_count, n_compared, len, k;
  time mt, t0, t4;

  // =========================================
  // Design and far-side model
  // =========================================
  // Short integration counts keep the run brief; the test pulse stays at its fixed length.
  voltage_readout #(.INTEG_50(200), .INTEG_60(150)) dut (.sys_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .mux_sel, .test_current, .integ_en, .over_limit, .conv_res, .meas, .meas_valid,
    .fault_led, .irq);
  adc_model partner (.sys_clk, .rstn, .mux_sel, .test_current, .integ_en, .cnt, .open_wire, .lag,
    .over_limit, .conv_res);

  // =========================================
  // Helpers
  // =========================================
  // Expected word: value clamped to 4095 units, left-justified, overflow and break in the low bits.
  function automatic logic [15:0] ew(input int c, input logic b);
    int s;
    s = c > 4095 ? 4095 : (c < -4095 ? -4095 : c);
    ew = {s[12:0], 1'b0, b, (c > 4095 || c < -4095)};
  endfunction

  // Ready is sampled on the falling edge, where it equals its value at the next rising edge.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic da, dw, tb;
    logic [1:0] r;
    da = 0;
    dw = 0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(negedge sys_clk);
      tb = s_axi_awready && !da;
      r[0] = s_axi_wready && !dw;
      @(posedge sys_clk);
      if (tb) s_axi_awvalid <= 1'b0;
      if (r[0]) s_axi_wvalid <= 1'b0;
      da |= tb;
      dw |= r[0];
    end
    while (!(da && dw));
    do
    begin
      @(negedge sys_clk);
      tb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge sys_clk);
    end
    while (!tb);
    s_axi_bready <= 1'b0;
    `CHK("bresp", er, r)
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic t;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(negedge sys_clk);
      t = s_axi_arready;
      @(posedge sys_clk);
    end
    while (!t);
    s_axi_arvalid <= 1'b0;
    do
    begin
      @(negedge sys_clk);
      t = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge sys_clk);
    end
    while (!t);
    s_axi_rready <= 1'b0;
    `CHK("rdata", e, d)
    `CHK("rresp", er, r)
  endtask

  // Waits for the next stored measurement and records it.
  // Only the watchdog ends this wait, so a stalled scan fails the run.
  task automatic wm();
    do
    begin
      @(negedge sys_clk);
    end
    while (meas_valid !== 1'b1);
    mc = meas.chan;
    mw = meas.word;
    mt = $time;
  endtask

  // Measures the next complete integration phase in cycles.
  task automatic il();
    int n;
    n = 0;
    len = 0;
    while (integ_en !== 1'b0 && n < 9000) begin @(negedge sys_clk); n++; end
    while (integ_en !== 1'b1 && n < 9000) begin @(negedge sys_clk); n++; end
    while (integ_en === 1'b1 && len < 9000) begin len++; @(negedge sys_clk); end
  endtask

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // =========================================
  // Clock, watchdog and tests
  // =========================================
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // The scan needs about 55000 cycles; this margin only cuts a hang short.
  initial
  begin
    #(90000 * 5);
    bad_count++;
    test_done();
  end

  initial
  begin
    {rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    open_wire = 4'h0;
    lag = 4'h1;
    cnt = '{16'sd2048, 16'sd4095, 16'sd5000, -16'sd5000};
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    rd(OFS_CTRL, 32'hc, RESP_OKAY);
    rd(OFS_IRQ_MASK, 32'h0, RESP_OKAY);
    rd(OFS_WORD0, 32'h0, RESP_OKAY);
    rd(8'h20, 32'h0, RESP_SLVERR);
    wr(OFS_WORD0, 32'h1, RESP_SLVERR);
    $display("test registers done");
    for (int r = 0; r < 2; r++)
    begin
      for (k = 0; k < 4; k++)
      begin
        wm();
        if (k == 0) begin t4 = mt - t0; t0 = mt; end
        `CHK("chan", k[1:0], mc)
        `CHK("word", ew(cnt[k], 1'b0), mw)
      end
      cnt = '{16'sd2049, -16'sd1, -16'sd2049, -16'sd4095};
    end
    rd(OFS_WORD3, {16'h0, ew(-4095, 1'b0)}, RESP_OKAY);
    $display("test format done");
    il();
    `CHK("integ 50", 200, len)
    wr(OFS_CTRL, 32'hd, RESP_OKAY);
    il();
    il();
    `CHK("integ 60", 150, len)
    wr(OFS_CTRL, 32'h8, RESP_OKAY);
    wm();
    wm();
    t0 = mt;
    wm();
    `CHK("one chan", 2'h0, mc)
    `CHK("faster", 1'b1, (mt - t0) * 3 < t4)
    lag = 4'h9;
    wr(OFS_CTRL, 32'ha, RESP_OKAY);
    wm();
    wm();
    pc = mc;
    for (k = 0; k < 4; k++)
    begin
      wm();
      `CHK("two chan", 1'b1, mc != pc && mc < 2'h2)
      pc = mc;
    end
    $display("test scan done");
    open_wire = 4'h1;
    lag = 4'h1;
    wr(OFS_CTRL, 32'h8, RESP_OKAY);
    wr(OFS_IRQ_MASK, 32'h80, RESP_OKAY);
    wm();
    wm();
    `CHK("break word", ew(2049, 1'b1), mw)
    @(negedge sys_clk);
    `CHK("led on", 1'b1, fault_led)
    `CHK("irq on", 1'b1, irq)
    wr(OFS_IRQ_STAT, 32'hff, RESP_OKAY);
    `CHK("irq off", 1'b0, irq)
    wr(OFS_CTRL, 32'h0, RESP_OKAY);
    wm();
    wm();
    `CHK("quiet word", ew(2049, 1'b0), mw)
    `CHK("led off", 1'b0, fault_led)
    rd(OFS_STATUS, 32'h10, RESP_OKAY);
    open_wire = 4'h0;
    wm();
    rd(OFS_STATUS, 32'h0, RESP_OKAY);
    $display("test break done");
    test_done();
  end
endmodule
